// [shared/owa_pkg.sv]
// Package with register map, field layout, reset values and bus carriers of the overlay window block.
package owa_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [9:0]  IDX_MAIN_STRIDE   = 10'h216;
  localparam logic [9:0]  IDX_OVL_ADDR_LO   = 10'h218;
  localparam logic [9:0]  IDX_OVL_ADDR_HI   = 10'h21a;
  localparam logic [9:0]  IDX_OVL_STATUS    = 10'h21c;
  localparam logic [9:0]  IDX_OVL_STRIDE    = 10'h21e;
  localparam logic [9:0]  IDX_OVL_LEFT      = 10'h220;

  // Field positions and widths.
  localparam int          STRIDE_W          = 12;
  localparam int          LEFT_W            = 10;
  localparam int          ADDR_HI_W         = 2;
  localparam int          ADDR_W            = 18;
  localparam int          VDBL_BIT          = 13;
  localparam int          HDBL_BIT          = 12;
  localparam int          IDX_LSB           = 2;
  localparam int          IDX_MSB           = 11;

  // Values after reset.
  localparam logic [15:0] RST_MAIN_STRIDE   = 16'h0000;
  localparam logic [15:0] RST_OVL_ADDR_LO   = 16'h0000;
  localparam logic [1:0]  RST_OVL_ADDR_HI   = 2'h0;
  localparam logic        RST_OVL_STATUS    = 1'b1;
  localparam logic [15:0] RST_OVL_STRIDE    = 16'h0000;
  localparam logic [9:0]  RST_OVL_LEFT      = 10'h000;
  localparam logic [1:0]  OVL_OFF           = 2'h0;

  // Bus answers.
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;

  // Master-to-slave signals of the register bus.
  typedef struct packed {
    logic        awvalid;
    logic [11:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [11:0] araddr;
    logic        rready;
  } owa_axi_req_t;

  // Slave-to-master signals of the register bus.
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } owa_axi_rsp_t;

  // Settings handed to the display refresh logic, valid for the current frame.
  typedef struct packed {
    logic [11:0] main_stride;
    logic        main_vdbl;
    logic        main_hdbl;
    logic        ovl_active;
    logic [17:0] ovl_addr;
    logic [11:0] ovl_stride;
    logic        ovl_vdbl;
    logic        ovl_hdbl;
    logic [9:0]  ovl_left;
  } owa_cfg_t;

endpackage

// [rtl/owa_sync.sv]
// Three-stage synchroniser that passes a level once the last two stages agree.
`timescale 1ns/1ps
module owa_sync (
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  input  wire logic i_ce,
  input  wire logic i_async,
  output logic      o_level
);

  logic s1_r, s2_r, s3_r, lvl_r;
  logic s1_nxt, s2_nxt, s3_nxt, lvl_nxt;

  // Only the second stage reads the first, so metastability stays contained.
  always_comb begin
    s1_nxt  = i_ce ? i_async : s1_r;
    s2_nxt  = i_ce ? s1_r : s2_r;
    s3_nxt  = i_ce ? s2_r : s3_r;
    lvl_nxt = (i_ce && (s2_r == s3_r)) ? s3_r : lvl_r;
  end

  // Registers of the chain.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s1_r  <= 1'b0;
      s2_r  <= 1'b0;
      s3_r  <= 1'b0;
      lvl_r <= 1'b0;
    end else begin
      s1_r  <= s1_nxt;
      s2_r  <= s2_nxt;
      s3_r  <= s3_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  assign o_level = lvl_r;

endmodule // owa_sync

// [rtl/owa_regs.sv]
// Overlay and main window addressing registers with an AXI4-Lite slave and frame shadowing.
//
// Behaviour
// R1 - Main stride bits 11-0 give byte distance between display line starts.
// R2 - Overlay stride bits 11-0 give byte distance between overlay line starts.
// R3 - Software programs stride as line pixels times bpp divided by eight.
// R4 - Software keeps 16 bpp stride and address even, stepping by pixel size.
// R5 - Overlay start address is 18 bits: low register 15-0, upper bits 1-0.
// R6 - Overlay start address is ignored while overlay enable field equals 00b.
// R7 - At 32 bpp software steps the overlay start address in 32-bit units.
// R8 - Upper overlay address bit 2 is reserved and reads zero.
// R9 - Without double buffering, status changes only after address writes; resets to 1.
// R10 - Status reads 0 while new address waits, 1 once the frame uses it.
// R11 - Double buffered with overlay front: status 0 shows back, 1 front.
// R12 - Overlay stride bit 13 enables vertical pixel doubling.
// R13 - Overlay stride bit 12 enables horizontal pixel doubling.
// R14 - With doubling, software sets start address per rotation mode formulas.
// R15 - Overlay left edge bits 9-0 give pixels from the panel origin.
// R16 - Camera overlay window size must equal the resized camera frame.
// R17 - Back buffer address locates the back frame, ignored without double buffering.
// R18 - Address, stride and doubling settings are taken at a frame boundary.
`timescale 1ns/1ps
module owa_regs (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_b,
  input  wire logic                  i_ce,
  input  wire owa_pkg::owa_axi_req_t i_axi,
  output owa_pkg::owa_axi_rsp_t      o_axi,
  input  wire logic                  i_vsync,
  input  wire logic [1:0]            i_ovl_enable,
  input  wire logic                  i_dbuf_en,
  input  wire logic                  i_main_front,
  input  wire logic [17:0]           i_back_addr,
  output owa_pkg::owa_cfg_t          o_cfg
);
  import owa_pkg::*;

  // Bus side state.
  logic         aw_held_r, aw_held_nxt;
  logic [9:0]   aw_idx_r, aw_idx_nxt;
  logic         w_held_r, w_held_nxt;
  logic [15:0]  wdata_r, wdata_nxt;
  logic [1:0]   wstrb_r, wstrb_nxt;
  owa_axi_rsp_t rsp_r, rsp_nxt;

  // Register and frame state.
  logic [15:0]  main_stride_r, main_stride_nxt;
  logic [15:0]  ovl_lo_r, ovl_lo_nxt;
  logic [1:0]   ovl_hi_r, ovl_hi_nxt;
  logic [15:0]  ovl_stride_r, ovl_stride_nxt;
  logic [9:0]   ovl_left_r, ovl_left_nxt;
  logic         status_r, status_nxt;
  logic         pending_r, pending_nxt;
  logic         shown_front_r, shown_front_nxt;
  logic         vs_prev_r, vs_prev_nxt;
  owa_cfg_t     cfg_r, cfg_nxt;

  // Decoded strobes.
  logic         vs_level;
  logic         frame_tick;
  logic         wr_fire;
  logic         wr_ok;
  logic         addr_write;
  logic         ar_fire;
  logic [9:0]   ar_idx;
  logic [15:0]  rd_val;
  logic         rd_ok;
  logic [15:0]  left_merged;

  // The frame pulse comes from the panel timing, which is not on our clock.
  owa_sync u_vs_sync (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_ce    (i_ce),
    .i_async (i_vsync),
    .o_level (vs_level)
  );

  // Apply byte strobes to a 16-bit register; only lanes 0 and 1 carry data.
  function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [15:0] new_v,
                                          input logic [1:0] strb);
    return {strb[1] ? new_v[15:8] : old_v[15:8], strb[0] ? new_v[7:0] : old_v[7:0]};
  endfunction

  // Strobes that tie the bus side to the register side.
  assign frame_tick = i_ce && vs_level && !vs_prev_r;
  assign wr_fire    = i_ce && aw_held_r && w_held_r && !rsp_r.bvalid;
  assign wr_ok      = (aw_idx_r == IDX_MAIN_STRIDE) || (aw_idx_r == IDX_OVL_ADDR_LO) ||
                      (aw_idx_r == IDX_OVL_ADDR_HI) || (aw_idx_r == IDX_OVL_STRIDE) ||
                      (aw_idx_r == IDX_OVL_LEFT);
  assign addr_write = wr_fire && (((aw_idx_r == IDX_OVL_ADDR_LO) && (wstrb_r != 2'h0)) ||
                                  ((aw_idx_r == IDX_OVL_ADDR_HI) && wstrb_r[0]));
  assign ar_fire    = i_ce && i_axi.arvalid && rsp_r.arready;
  assign ar_idx     = i_axi.araddr[IDX_MSB:IDX_LSB];
  // The left edge is merged at full width first, then cut to its field.
  assign left_merged = merge16({6'h00, ovl_left_r}, wdata_r, wstrb_r);

  // Read multiplexer; reserved bits read as zero, the status register is read only.
  always_comb begin
    rd_val = 16'h0000;
    rd_ok  = 1'b1;
    case (ar_idx)
      IDX_MAIN_STRIDE: rd_val = {2'h0, main_stride_r[13:0]};
      IDX_OVL_ADDR_LO: rd_val = ovl_lo_r;
      IDX_OVL_ADDR_HI: rd_val = {14'h0000, ovl_hi_r};                 // [R8]
      IDX_OVL_STATUS:  rd_val = {15'h0000, status_r};
      IDX_OVL_STRIDE:  rd_val = {2'h0, ovl_stride_r[13:0]};
      IDX_OVL_LEFT:    rd_val = {6'h00, ovl_left_r};
      default:         rd_ok  = 1'b0;
    endcase
  end

  // Bus handshakes: address and data are taken in either order, the answer follows both.
  always_comb begin
    aw_held_nxt = aw_held_r;
    aw_idx_nxt  = aw_idx_r;
    w_held_nxt  = w_held_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    rsp_nxt     = rsp_r;
    if (i_ce) begin
      if (i_axi.awvalid && rsp_r.awready) begin
        aw_held_nxt = 1'b1;
        aw_idx_nxt  = i_axi.awaddr[IDX_MSB:IDX_LSB];
      end
      if (i_axi.wvalid && rsp_r.wready) begin
        w_held_nxt = 1'b1;
        wdata_nxt  = i_axi.wdata[15:0];
        wstrb_nxt  = i_axi.wstrb[1:0];
      end
      if (rsp_r.bvalid && i_axi.bready) begin
        rsp_nxt.bvalid = 1'b0;
      end
      if (wr_fire) begin
        aw_held_nxt    = 1'b0;
        w_held_nxt     = 1'b0;
        rsp_nxt.bvalid = 1'b1;
        rsp_nxt.bresp  = wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      rsp_nxt.awready = !aw_held_nxt && !rsp_nxt.bvalid;
      rsp_nxt.wready  = !w_held_nxt && !rsp_nxt.bvalid;
      if (rsp_r.rvalid && i_axi.rready) begin
        rsp_nxt.rvalid = 1'b0;
      end
      if (ar_fire) begin
        rsp_nxt.rvalid = 1'b1;
        rsp_nxt.rdata  = {16'h0000, rd_val};
        rsp_nxt.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      rsp_nxt.arready = !rsp_nxt.rvalid;
    end
  end

  // Bus side registers.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      aw_held_r <= 1'b0;
      aw_idx_r  <= 10'h000;
      w_held_r  <= 1'b0;
      wdata_r   <= 16'h0000;
      wstrb_r   <= 2'h0;
      rsp_r     <= '0;
    end else begin
      aw_held_r <= aw_held_nxt;
      aw_idx_r  <= aw_idx_nxt;
      w_held_r  <= w_held_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      rsp_r     <= rsp_nxt;
    end
  end

  // Register writes, frame status and the frame-boundary copy into the live settings.
  always_comb begin
    main_stride_nxt = main_stride_r;
    ovl_lo_nxt      = ovl_lo_r;
    ovl_hi_nxt      = ovl_hi_r;
    ovl_stride_nxt  = ovl_stride_r;
    ovl_left_nxt    = ovl_left_r;
    status_nxt      = status_r;
    pending_nxt     = pending_r;
    shown_front_nxt = shown_front_r;
    vs_prev_nxt     = vs_prev_r;
    cfg_nxt         = cfg_r;
    if (i_ce) begin
      vs_prev_nxt = vs_level;
      if (wr_fire) begin
        case (aw_idx_r)
          IDX_MAIN_STRIDE: main_stride_nxt = merge16(main_stride_r, wdata_r, wstrb_r);
          IDX_OVL_ADDR_LO: ovl_lo_nxt      = merge16(ovl_lo_r, wdata_r, wstrb_r);   // [R5]
          IDX_OVL_ADDR_HI: ovl_hi_nxt      = wstrb_r[0] ? wdata_r[1:0] : ovl_hi_r;  // [R5] [R8]
          IDX_OVL_STRIDE:  ovl_stride_nxt  = merge16(ovl_stride_r, wdata_r, wstrb_r);
          IDX_OVL_LEFT:    ovl_left_nxt    = left_merged[LEFT_W-1:0];                // [R15]
          default:         ovl_left_nxt    = ovl_left_r;
        endcase
      end
      // A new frame takes every setting at once (the address only while the overlay is enabled), so a line never mixes old and new values.
      if (frame_tick) begin
        shown_front_nxt    = i_dbuf_en ? !shown_front_r : 1'b1;
        cfg_nxt.main_stride = main_stride_r[STRIDE_W-1:0];                    // [R1] [R18]
        cfg_nxt.main_vdbl   = main_stride_r[VDBL_BIT];
        cfg_nxt.main_hdbl   = main_stride_r[HDBL_BIT];
        cfg_nxt.ovl_stride  = ovl_stride_r[STRIDE_W-1:0];                     // [R2] [R18]
        cfg_nxt.ovl_vdbl    = ovl_stride_r[VDBL_BIT];                         // [R12]
        cfg_nxt.ovl_hdbl    = ovl_stride_r[HDBL_BIT];                         // [R13]
        cfg_nxt.ovl_left    = ovl_left_r;                                     // [R15]
        cfg_nxt.ovl_active  = (i_ovl_enable != OVL_OFF);
        // A disabled overlay leaves the live address untouched.
        if (i_ovl_enable != OVL_OFF) begin                                    // [R6]
          if (i_dbuf_en && !shown_front_nxt) begin
            cfg_nxt.ovl_addr = i_back_addr;                                   // [R17]
          end else begin
            cfg_nxt.ovl_addr = {ovl_hi_r, ovl_lo_r};                          // [R5] [R18]
          end
        end
        pending_nxt = 1'b0;
      end
      // Status: frame take-up when single buffered, shown buffer when overlay is the front.
      if (!i_dbuf_en) begin
        if (frame_tick && pending_r) begin
          status_nxt = 1'b1;                                                  // [R10]
        end
      end else if (!i_main_front) begin
        status_nxt = shown_front_nxt;                                         // [R11]
      end
      // An address write in the same cycle as the frame edge wins and waits for the next one.
      if (addr_write) begin
        pending_nxt = 1'b1;
        if (!i_dbuf_en) begin
          status_nxt = 1'b0;                                                  // [R9] [R10]
        end
      end
    end
  end

  // Register side flip-flops.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      main_stride_r <= RST_MAIN_STRIDE;
      ovl_lo_r      <= RST_OVL_ADDR_LO;
      ovl_hi_r      <= RST_OVL_ADDR_HI;
      ovl_stride_r  <= RST_OVL_STRIDE;
      ovl_left_r    <= RST_OVL_LEFT;
      status_r      <= RST_OVL_STATUS;                                        // [R9]
      pending_r     <= 1'b0;
      shown_front_r <= 1'b1;
      vs_prev_r     <= 1'b0;
      cfg_r         <= '0;
    end else begin
      main_stride_r <= main_stride_nxt;
      ovl_lo_r      <= ovl_lo_nxt;
      ovl_hi_r      <= ovl_hi_nxt;
      ovl_stride_r  <= ovl_stride_nxt;
      ovl_left_r    <= ovl_left_nxt;
      status_r      <= status_nxt;
      pending_r     <= pending_nxt;
      shown_front_r <= shown_front_nxt;
      vs_prev_r     <= vs_prev_nxt;
      cfg_r         <= cfg_nxt;
    end
  end

  assign o_axi = rsp_r;
  assign o_cfg = cfg_r;

endmodule // owa_regs

// [dv/owa_regs_properties.sv]
// Checker with bus and frame-update properties of the overlay window registers.
`timescale 1ns/1ps
module owa_regs_properties
  import owa_pkg::*;
(
  input wire logic         i_clk,
  input wire logic         i_rst_b,
  input wire logic         i_ce,
  input wire owa_axi_req_t i_axi,
  input wire owa_axi_rsp_t o_axi,
  input wire logic         i_vsync,
  input wire logic [1:0]   i_ovl_enable,
  input wire logic         i_dbuf_en,
  input wire logic         i_main_front,
  input wire logic [17:0]  i_back_addr,
  input wire owa_cfg_t     o_cfg
);
  logic [9:0] rd_idx_r;
  logic [3:0] lo_cnt_r;

  // Keep the read index and count low vsync cycles; after eight no frame tick can be pending.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rd_idx_r <= 10'h000;
      lo_cnt_r <= 4'h0;
    end else begin
      if (i_axi.arvalid && o_axi.arready) rd_idx_r <= i_axi.araddr[11:2];
      lo_cnt_r <= i_vsync ? 4'h0 : lo_cnt_r + {3'h0, lo_cnt_r != 4'hf};
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  property p_r_hold; o_axi.rvalid && !i_axi.rready |=> o_axi.rvalid && $stable(o_axi.rdata);
  endproperty
  property p_b_hold; o_axi.bvalid && !i_axi.bready |=> o_axi.bvalid && $stable(o_axi.bresp);
  endproperty
  property p_r_ans; i_axi.arvalid && o_axi.arready && i_ce |=> o_axi.rvalid && !o_axi.arready;
  endproperty
  property p_aw_low; o_axi.bvalid |-> !o_axi.awready && !o_axi.wready; endproperty
  property p_cfg_hold; lo_cnt_r >= 4'h8 |-> $stable(o_cfg); endproperty
  property p_ovl_act; !$stable(o_cfg) |-> o_cfg.ovl_active == ($past(i_ovl_enable) != OVL_OFF);
  endproperty
  property p_hi_rsv; o_axi.rvalid && rd_idx_r == IDX_OVL_ADDR_HI |-> o_axi.rdata[31:2] == 30'h0;
  endproperty
  property p_stat; o_axi.rvalid && rd_idx_r == IDX_OVL_STATUS |-> o_axi.rdata[31:1] == 31'h0;
  endproperty

  a_r_hold: assert property (p_r_hold) else $error("read answer dropped early");
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
  a_r_ans: assert property (p_r_ans) else $error("read answer late");
  a_aw_low: assert property (p_aw_low) else $error("write accepted during answer");
  a_cfg_hold: assert property (p_cfg_hold) else $error("settings moved without frame");
  a_ovl_act: assert property (p_ovl_act) else $error("overlay active wrong");
  a_hi_rsv: assert property (p_hi_rsv) else $error("reserved address bits set");
  a_stat: assert property (p_stat) else $error("status upper bits set");

  c_cfg: cover property (!$stable(o_cfg));
  c_stat: cover property (o_axi.rvalid && rd_idx_r == IDX_OVL_STATUS);
  c_err: cover property (o_axi.bvalid && o_axi.bresp == RESP_SLVERR);
endmodule // owa_regs_properties

bind owa_regs owa_regs_properties u_props (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce),
  .i_axi(i_axi), .o_axi(o_axi), .i_vsync(i_vsync), .i_ovl_enable(i_ovl_enable),
  .i_dbuf_en(i_dbuf_en), .i_main_front(i_main_front), .i_back_addr(i_back_addr),
  .o_cfg(o_cfg));

// [dv/owa_regs_tb.sv]
// Self-checking testbench of the overlay window addressing registers.
`timescale 1ns/1ps
module owa_regs_tb;
  import owa_pkg::*;
  localparam logic [9:0]  IDX [6] = '{IDX_MAIN_STRIDE, IDX_OVL_ADDR_LO, IDX_OVL_ADDR_HI,
                                      IDX_OVL_STATUS, IDX_OVL_STRIDE, IDX_OVL_LEFT};
  localparam logic [15:0] MSK [6] = '{16'h3fff, 16'hffff, 16'h0003, 16'h0, 16'h3fff, 16'h03ff};
  logic         i_clk = 1'b0;
  logic         i_rst_b, i_ce, i_vsync, i_dbuf_en, i_main_front, st, prev_s;
  logic [1:0]   i_ovl_enable;
  logic [17:0]  i_back_addr, a_live;
  logic [15:0]  mdl [6];
  logic [31:0]  q;
  owa_axi_req_t rq;
  owa_axi_rsp_t rs;
  owa_cfg_t     cfg;
  int           failures = 0;
  int           n_tests = 0;

  // Free-running 100 MHz clock.
  always #5 i_clk = ~i_clk;

  owa_regs uut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_axi(rq), .o_axi(rs),
    .i_vsync(i_vsync), .i_ovl_enable(i_ovl_enable), .i_dbuf_en(i_dbuf_en),
    .i_main_front(i_main_front), .i_back_addr(i_back_addr), .o_cfg(cfg));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic hang();
    failures++;
    $display("mismatch at %0t: bus timeout", $time);
    give_verdict();
  endtask

  // Address and data are offered together; each is dropped once its ready is seen.
  task automatic wr(input logic [9:0] idx, input logic [15:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    rq.awaddr <= {idx, 2'b00};
    rq.wdata <= {16'($urandom), d};
    rq.wstrb <= s;
    rq.awvalid <= 1'b1;
    rq.wvalid <= 1'b1;
    rq.bready <= 1'b1;
    for (int i = 0; i < 60; i++) begin
      @(posedge i_clk);
      if (rq.awvalid && rs.awready) rq.awvalid <= 1'b0;
      if (rq.wvalid && rs.wready) rq.wvalid <= 1'b0;
      if (rs.bvalid) begin
        rq.bready <= 1'b0;
        chk(32'(rs.bresp), 32'(er), "write response");
        @(posedge i_clk);
        return;
      end
    end
    hang();
  endtask

  task automatic rd(input logic [9:0] idx, input logic [1:0] er, output logic [31:0] d);
    rq.araddr <= {idx, 2'b00};
    rq.arvalid <= 1'b1;
    rq.rready <= 1'b1;
    for (int i = 0; i < 60; i++) begin
      @(posedge i_clk);
      if (rq.arvalid && rs.arready) rq.arvalid <= 1'b0;
      if (rs.rvalid) begin
        rq.rready <= 1'b0;
        d = rs.rdata;
        chk(32'(rs.rresp), 32'(er), "read response");
        @(posedge i_clk);
        return;
      end
    end
    hang();
  endtask

  // Model update: strobed bytes land through the field mask; status writes are refused.
  task automatic put(input int k, input logic [15:0] d, input logic [3:0] s);
    wr(IDX[k], d, s, (k == 3) ? RESP_SLVERR : RESP_OKAY);
    if (k != 3 && s[0]) mdl[k][7:0] = d[7:0] & MSK[k][7:0];
    if (k != 3 && s[1]) mdl[k][15:8] = d[15:8] & MSK[k][15:8];
    if ((k == 1 && s[1:0] != 2'b00) || (k == 2 && s[0])) st = 1'b0;
  endtask

  function automatic logic [31:0] ev(input int k);
    return (k == 3) ? {31'h0, st} : {16'h0, mdl[k]};
  endfunction

  task automatic read_all();
    for (int k = 0; k < 6; k++) begin
      rd(IDX[k], (k == 3) ? RESP_OKAY : RESP_OKAY, q);
      chk(q, ev(k), "register value");
    end
  endtask

  // A frame is a vsync pulse long enough for the synchroniser, then a quiet gap.
  task automatic frame();
    i_vsync <= 1'b1;
    repeat (8) @(posedge i_clk);
    i_vsync <= 1'b0;
    repeat (10) @(posedge i_clk);
  endtask

  task automatic cfg_chk(input logic act, input logic [17:0] a);
    chk(32'(cfg.ovl_active), 32'(act), "overlay active");
    chk(32'(cfg.ovl_addr), 32'(a), "overlay address");
    chk(32'({cfg.ovl_vdbl, cfg.ovl_hdbl, cfg.ovl_stride}), 32'(mdl[4][13:0]), "stride");
    chk(32'(cfg.ovl_left), 32'(mdl[5][9:0]), "left edge");
    chk(32'({cfg.main_vdbl, cfg.main_hdbl, cfg.main_stride}), 32'(mdl[0][13:0]), "main");
  endtask

  // Main sequence: reset values, writes, frame take-up, refusals, enable codes, double buffer.
  initial begin
    rq = '0;
    i_rst_b = 1'b0;
    i_ce = 1'b1;
    i_vsync = 1'b0;
    i_ovl_enable = 2'h1;
    i_dbuf_en = 1'b0;
    i_main_front = 1'b0;
    void'($urandom(32'h46da53a2));
    i_back_addr = 18'($urandom) | 18'h1;
    mdl = '{RST_MAIN_STRIDE, RST_OVL_ADDR_LO, 16'(RST_OVL_ADDR_HI), 16'h0, RST_OVL_STRIDE,
            16'(RST_OVL_LEFT)};
    st = RST_OVL_STATUS;
    repeat (10) @(posedge i_clk);
    i_rst_b <= 1'b1;
    repeat (2) @(posedge i_clk);
    read_all();
    for (int n = 0; n < 3; n++) begin
      for (int k = 0; k < 6; k++) put(k, 16'($urandom), (n == 2) ? 4'b0010 : 4'hf);
    end
    read_all();
    chk(32'(cfg.ovl_addr), 32'h0, "address before frame");
    frame();
    st = 1'b1;
    read_all();
    cfg_chk(1'b1, {mdl[2][1:0], mdl[1]});
    a_live = {mdl[2][1:0], mdl[1]};
    frame();
    read_all();
    foreach (IDX[k]) begin
      wr(IDX[k] + 10'h1, 16'hffff, 4'hf, RESP_SLVERR);
      rd(IDX[k] + 10'h1, RESP_SLVERR, q);
      chk(q, 32'h0, "unmapped read");
    end
    for (int en = 0; en < 4; en++) begin
      i_ovl_enable <= 2'(en);
      put(1, 16'($urandom) & 16'hfffe, 4'h3);
      if (en != 0) a_live = {mdl[2][1:0], mdl[1]};
      frame();
      cfg_chk(en != 0, a_live);
    end
    // Software setup for 160-pixel lines at 16 bpp with doubling at rotation 0.
    put(4, 16'h3000 | 16'(160 * 16 / 8), 4'h3);
    put(0, 16'(160 * 16 / 8), 4'h3);
    put(2, 16'h0000, 4'h1);
    put(1, 16'h0000, 4'h3);
    // A frame edge that comes and goes while the clock enable is low is never seen.
    i_ce <= 1'b0;
    frame();
    i_ce <= 1'b1;
    rd(IDX[3], RESP_OKAY, q);
    chk(q, ev(3), "status after frozen frame");
    chk(32'(cfg.ovl_addr), 32'(a_live), "address after frozen frame");
    frame();
    st = 1'b1;
    read_all();
    cfg_chk(1'b1, 18'h0);
    put(1, 16'($urandom) & 16'hfffc, 4'h3);
    frame();
    st = 1'b1;
    cfg_chk(1'b1, {mdl[2][1:0], mdl[1]});
    // Double buffering: the shown buffer flips at every frame, starting from the back one.
    i_dbuf_en <= 1'b1;
    for (int f = 0; f < 4; f++) begin
      frame();
      st = !st;
      rd(IDX[3], RESP_OKAY, q);
      chk(32'(q[0]), 32'(st), "shown buffer");
      if (f != 0) chk(32'(q[0] != prev_s), 32'h1, "buffer toggle");
      prev_s = q[0];
      cfg_chk(1'b1, st ? {mdl[2][1:0], mdl[1]} : i_back_addr);
    end
    // With the main window as front the status holds while the buffers keep flipping.
    i_main_front <= 1'b1;
    frame();
    rd(IDX[3], RESP_OKAY, q);
    chk(32'(q[0]), 32'(st), "status while main is front");
    cfg_chk(1'b1, st ? i_back_addr : {mdl[2][1:0], mdl[1]});
    give_verdict();
  end
endmodule // owa_regs_tb
